// ---- logic/cmd_pkg.sv ----
// Shared constants and types for the serial mode command parser.
`default_nettype none

package cmd_pkg;

  // ----------------------------------------------------------------
  // Frame characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_MEASURE = 8'h4d;
  localparam logic [7:0] CH_ZERO_CAL = 8'h4e;
  localparam logic [7:0] CH_SPAN_CAL = 8'h4b;
  localparam logic [23:0] ID_ALL_ZERO = 24'h303030;
  localparam logic [23:0] ID_ANY = 24'h3f3f3f;
  localparam logic [1:0] ID_LEN = 2'h3;

  // ----------------------------------------------------------------
  // Modes and parser states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_MEASURE = 2'b00,
    MODE_ZERO = 2'b01,
    MODE_SPAN = 2'b10
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR_S = 3'b001,
    ST_HDR_T = 3'b010,
    ST_ID = 3'b011,
    ST_CMD = 3'b100,
    ST_ETX = 3'b101,
    ST_CHK_HI = 3'b110,
    ST_CHK_LO = 3'b111
  } parse_e;

  // ----------------------------------------------------------------
  // Failure byte and fault pin positions
  // ----------------------------------------------------------------
  localparam int FAIL_FLOW = 0;
  localparam int FAIL_INSTR = 1;
  localparam int FAIL_LAMP = 3;
  localparam int FAIL_HEATER = 5;
  localparam int PIN_FLOW = 0;
  localparam int PIN_INSTR = 1;
  localparam int PIN_MAINT = 2;
  localparam int PIN_LAMP = 3;
  localparam int PIN_HEATER = 4;
  localparam int PIN_W = 5;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATION = 12'h004;
  localparam logic [11:0] ADDR_MODE = 12'h008;
  localparam logic [11:0] ADDR_FAIL = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
  localparam logic [11:0] ADDR_COUNT = 12'h018;
  localparam logic [11:0] ADDR_LAST = 12'h01c;
  localparam int CTRL_EN = 0;
  localparam int CTRL_CLR_CNT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int MODE_OOS = 2;
  localparam int EV_ACCEPT = 0;
  localparam int EV_DROP = 1;
  localparam int EV_BADCMD = 2;
  localparam int EV_IDSKIP = 3;
  localparam int EV_FAIL = 4;
  localparam int EV_W = 5;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;

endpackage : cmd_pkg

`default_nettype wire

// ---- logic/hex_nibble_decode.sv ----
// Converts one ASCII hexadecimal character into its four-bit value.
`timescale 1ns/10ps
`default_nettype none

module hex_nibble_decode (
  input wire logic [7:0] ch,
  output logic [3:0] nib,
  output logic ok
);

  always_comb begin
    nib = 4'h0;
    ok = 1'b0;
    if (ch >= 8'h30 && ch <= 8'h39) begin
      nib = ch[3:0];
      ok = 1'b1;
    end else if ((ch >= 8'h41 && ch <= 8'h46) || (ch >= 8'h61 && ch <= 8'h66)) begin
      // Lower case is accepted too; it costs nothing and some loggers send it.
      nib = 4'(ch[3:0] + 4'h9);
      ok = 1'b1;
    end
  end

endmodule : hex_nibble_decode

`default_nettype wire

// ---- logic/station_id_match.sv ----
// Decides whether a received station identifier addresses this device.
`timescale 1ns/10ps
`default_nettype none

module station_id_match (
  input wire logic id_present,
  input wire logic [23:0] rx_id,
  input wire logic [23:0] own_id,
  output logic match
);

  assign match = !id_present || (rx_id == own_id) ||
                 (rx_id == cmd_pkg::ID_ALL_ZERO) || (rx_id == cmd_pkg::ID_ANY);

endmodule : station_id_match

`default_nettype wire

// ---- logic/serial_mode_command_parser.sv ----
// Mode-setting command interpreter with failure byte encoder and APB registers.
//
// Summary of operation
// - Failure byte is positive logic and bit 0 reports a flow sensor failure.
// - Bit 1 reports a general instrument failure and never maintenance alone.
// - Bit 3 reports a lamp failure on variants that have a lamp.
// - Bit 5 reports a cell heater failure on variants with a heated cell.
// - A request is STX, S, T, an optional identifier, a space, a letter, ETX, two check chars.
// - Only the own identifier, 000 or ??? (or none) lets a request act.
// - Letter M selects measure, N selects zero and K selects span mode.
// - No reply of any kind is sent for a mode-setting request.
// - Frames open with byte 0x02 and close their text with byte 0x03.
// - The check value starts at zero and XORs every byte from STX to ETX inclusive.
// - The check value follows ETX as two hex characters, upper nibble first.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module serial_mode_command_parser #(
  parameter bit HAS_LAMP = 1'b1,
  parameter bit HAS_HEATED_CELL = 1'b1,
  parameter logic [23:0] STATION_ID_RST = 24'h303031
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cmd_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic flow_fault,
  input wire logic instr_fault,
  input wire logic in_maintenance,
  input wire logic lamp_fault,
  input wire logic heater_fault,
  output logic [1:0] mode,
  output logic [7:0] failure_byte,
  output logic out_of_service,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cmd_pkg::parse_e state_q;
  cmd_pkg::parse_e state_d;
  cmd_pkg::mode_e mode_q;
  logic syntax_err;
  logic [7:0] xor_q;
  logic [1:0] id_cnt_q;
  logic [23:0] id_q;
  logic id_present_q;
  logic [7:0] cmd_q;
  logic [3:0] hi_q;
  logic [3:0] hex_nib;
  logic hex_ok;
  logic id_match;
  logic frame_end;
  logic chk_ok;
  logic cmd_ok;
  logic accept;
  logic [cmd_pkg::PIN_W-1:0] pins;
  logic [cmd_pkg::PIN_W-1:0] sync1_q;
  logic [cmd_pkg::PIN_W-1:0] sync2_q;
  logic [cmd_pkg::PIN_W-1:0] sync3_q;
  logic [cmd_pkg::PIN_W-1:0] stable_q;
  logic [7:0] failure_d;
  logic [7:0] failure_q;
  logic ctrl_en_q;
  logic [23:0] station_q;
  logic [cmd_pkg::EV_W-1:0] irq_stat_q;
  logic [cmd_pkg::EV_W-1:0] irq_mask_q;
  logic [cmd_pkg::EV_W-1:0] events;
  logic [15:0] accept_cnt_q;
  logic [15:0] drop_cnt_q;
  logic [31:0] last_q;
  logic [31:0] prdata_q;
  logic wr_en;
  logic setup;
  logic mapped;
  logic clr_cnt;

  // ----------------------------------------------------------------
  // Frame parser
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    syntax_err = 1'b0;
    if (!ctrl_en_q) begin
      state_d = cmd_pkg::ST_IDLE;
    end else if (rx_valid) begin
      if (rx_data == cmd_pkg::CH_STX) begin
        state_d = cmd_pkg::ST_HDR_S;
        syntax_err = (state_q != cmd_pkg::ST_IDLE);
      end else begin
        unique case (state_q)
          cmd_pkg::ST_IDLE: begin
            state_d = cmd_pkg::ST_IDLE;
          end
          cmd_pkg::ST_HDR_S: begin
            state_d = (rx_data == cmd_pkg::CH_S) ? cmd_pkg::ST_HDR_T : cmd_pkg::ST_IDLE;
            syntax_err = (rx_data != cmd_pkg::CH_S);
          end
          cmd_pkg::ST_HDR_T: begin
            state_d = (rx_data == cmd_pkg::CH_T) ? cmd_pkg::ST_ID : cmd_pkg::ST_IDLE;
            syntax_err = (rx_data != cmd_pkg::CH_T);
          end
          cmd_pkg::ST_ID: begin
            if (rx_data == cmd_pkg::CH_SPACE) begin
              if (id_cnt_q == 2'h0 || id_cnt_q == cmd_pkg::ID_LEN) begin
                state_d = cmd_pkg::ST_CMD;
              end else begin
                state_d = cmd_pkg::ST_IDLE;
                syntax_err = 1'b1;
              end
            end else if (id_cnt_q == cmd_pkg::ID_LEN || rx_data == cmd_pkg::CH_ETX) begin
              state_d = cmd_pkg::ST_IDLE;
              syntax_err = 1'b1;
            end
          end
          cmd_pkg::ST_CMD: begin
            state_d = (rx_data == cmd_pkg::CH_ETX) ? cmd_pkg::ST_IDLE : cmd_pkg::ST_ETX;
            syntax_err = (rx_data == cmd_pkg::CH_ETX);
          end
          cmd_pkg::ST_ETX: begin
            state_d = (rx_data == cmd_pkg::CH_ETX) ? cmd_pkg::ST_CHK_HI : cmd_pkg::ST_IDLE;
            syntax_err = (rx_data != cmd_pkg::CH_ETX);
          end
          cmd_pkg::ST_CHK_HI: begin
            state_d = hex_ok ? cmd_pkg::ST_CHK_LO : cmd_pkg::ST_IDLE;
            syntax_err = !hex_ok;
          end
          cmd_pkg::ST_CHK_LO: begin
            state_d = cmd_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= cmd_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // running XOR from STX to ETX
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xor_q <= 8'h00;
    end else if (rx_valid && rx_data == cmd_pkg::CH_STX) begin
      xor_q <= 8'h00 ^ rx_data;
    end else if (rx_valid && state_q != cmd_pkg::ST_IDLE && state_q != cmd_pkg::ST_CHK_HI &&
                 state_q != cmd_pkg::ST_CHK_LO) begin
      xor_q <= xor_q ^ rx_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      id_cnt_q <= 2'h0;
      id_q <= 24'h000000;
      id_present_q <= 1'b0;
    end else if (state_d == cmd_pkg::ST_HDR_S) begin
      id_cnt_q <= 2'h0;
      id_present_q <= 1'b0;
    end else if (rx_valid && state_q == cmd_pkg::ST_ID) begin
      if (rx_data == cmd_pkg::CH_SPACE) begin
        id_present_q <= (id_cnt_q == cmd_pkg::ID_LEN);
      end else begin
        id_q <= {id_q[15:0], rx_data};
        id_cnt_q <= 2'(id_cnt_q + 2'h1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= 8'h00;
      hi_q <= 4'h0;
    end else if (rx_valid && state_q == cmd_pkg::ST_CMD) begin
      cmd_q <= rx_data;
    end else if (rx_valid && state_q == cmd_pkg::ST_CHK_HI) begin
      hi_q <= hex_nib;
    end
  end

  hex_nibble_decode u_hex (
    .ch(rx_data),
    .nib(hex_nib),
    .ok(hex_ok)
  );

  station_id_match u_id (
    .id_present(id_present_q),
    .rx_id(id_q),
    .own_id(station_q),
    .match(id_match)
  );

  // ----------------------------------------------------------------
  // Frame evaluation
  // ----------------------------------------------------------------
  assign frame_end = ctrl_en_q && rx_valid && state_q == cmd_pkg::ST_CHK_LO &&
                     rx_data != cmd_pkg::CH_STX;
  // lower nibble completes the check value
  assign chk_ok = hex_ok && ({hi_q, hex_nib} == xor_q);
  assign cmd_ok = (cmd_q == cmd_pkg::CH_MEASURE) || (cmd_q == cmd_pkg::CH_ZERO_CAL) ||
                  (cmd_q == cmd_pkg::CH_SPAN_CAL);
  // bad check or letter is discarded
  assign accept = frame_end && chk_ok && cmd_ok && id_match;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= cmd_pkg::MODE_MEASURE;
    end else if (accept) begin
      if (cmd_q == cmd_pkg::CH_ZERO_CAL) begin
        mode_q <= cmd_pkg::MODE_ZERO;
      end else if (cmd_q == cmd_pkg::CH_SPAN_CAL) begin
        mode_q <= cmd_pkg::MODE_SPAN;
      end else begin
        mode_q <= cmd_pkg::MODE_MEASURE;
      end
    end
  end

  assign mode = mode_q;

  // ----------------------------------------------------------------
  // Fault inputs and failure byte
  // ----------------------------------------------------------------
  assign pins = {heater_fault, lamp_fault, in_maintenance, instr_fault, flow_fault};

  // Fault lines are asynchronous pins, so a change only counts once two stages agree.
  for (genvar g = 0; g < cmd_pkg::PIN_W; g++) begin : g_sync
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        sync1_q[g] <= 1'b0;
        sync2_q[g] <= 1'b0;
        sync3_q[g] <= 1'b0;
        stable_q[g] <= 1'b0;
      end else begin
        sync1_q[g] <= pins[g];
        sync2_q[g] <= sync1_q[g];
        sync3_q[g] <= sync2_q[g];
        if (sync2_q[g] == sync3_q[g]) begin
          stable_q[g] <= sync3_q[g];
        end
      end
    end
  end

  always_comb begin
    failure_d = 8'h00;
    failure_d[cmd_pkg::FAIL_FLOW] = stable_q[cmd_pkg::PIN_FLOW];
    failure_d[cmd_pkg::FAIL_INSTR] = stable_q[cmd_pkg::PIN_INSTR];
    failure_d[cmd_pkg::FAIL_LAMP] = HAS_LAMP && stable_q[cmd_pkg::PIN_LAMP];
    failure_d[cmd_pkg::FAIL_HEATER] = HAS_HEATED_CELL && stable_q[cmd_pkg::PIN_HEATER];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      failure_q <= 8'h00;
    end else begin
      failure_q <= failure_d;
    end
  end

  assign failure_byte = failure_q;
  assign out_of_service = stable_q[cmd_pkg::PIN_MAINT];

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  assign events[cmd_pkg::EV_ACCEPT] = accept;
  assign events[cmd_pkg::EV_DROP] = syntax_err || (frame_end && !chk_ok);
  assign events[cmd_pkg::EV_BADCMD] = frame_end && chk_ok && id_match && !cmd_ok;
  assign events[cmd_pkg::EV_IDSKIP] = frame_end && chk_ok && !id_match;
  assign events[cmd_pkg::EV_FAIL] = (failure_d != failure_q);

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && mapped;

  // A new event in the cycle of a write-one clear keeps its bit set.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= '0;
    end else if (wr_en && paddr == cmd_pkg::ADDR_IRQ_STAT && pstrb[0]) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[cmd_pkg::EV_W-1:0]) | events;
    end else begin
      irq_stat_q <= irq_stat_q | events;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  always_comb begin
    unique case (paddr)
      cmd_pkg::ADDR_CTRL, cmd_pkg::ADDR_STATION, cmd_pkg::ADDR_MODE, cmd_pkg::ADDR_FAIL,
      cmd_pkg::ADDR_IRQ_STAT, cmd_pkg::ADDR_IRQ_MASK, cmd_pkg::ADDR_COUNT,
      cmd_pkg::ADDR_LAST: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign clr_cnt = wr_en && paddr == cmd_pkg::ADDR_CTRL && pstrb[0] &&
                   pwdata[cmd_pkg::CTRL_CLR_CNT];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_en_q <= cmd_pkg::CTRL_EN_RST;
      irq_mask_q <= cmd_pkg::IRQ_MASK_RST;
    end else if (wr_en && pstrb[0]) begin
      if (paddr == cmd_pkg::ADDR_CTRL) begin
        ctrl_en_q <= pwdata[cmd_pkg::CTRL_EN];
      end
      if (paddr == cmd_pkg::ADDR_IRQ_MASK) begin
        irq_mask_q <= pwdata[cmd_pkg::EV_W-1:0];
      end
    end
  end

  for (genvar b = 0; b < 3; b++) begin : g_station
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        station_q[8*b +: 8] <= STATION_ID_RST[8*b +: 8];
      end else if (wr_en && paddr == cmd_pkg::ADDR_STATION && pstrb[b]) begin
        station_q[8*b +: 8] <= pwdata[8*b +: 8];
      end
    end
  end

  // Counters wrap rather than saturate; software reads deltas.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accept_cnt_q <= 16'h0000;
      drop_cnt_q <= 16'h0000;
    end else if (clr_cnt) begin
      accept_cnt_q <= 16'h0000;
      drop_cnt_q <= 16'h0000;
    end else begin
      if (accept) begin
        accept_cnt_q <= 16'(accept_cnt_q + 16'h0001);
      end
      if (events[cmd_pkg::EV_DROP] || events[cmd_pkg::EV_BADCMD]) begin
        drop_cnt_q <= 16'(drop_cnt_q + 16'h0001);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_q <= 32'h00000000;
    end else if (accept) begin
      last_q <= {id_q, cmd_q};
    end
  end

  // Read data is captured in the setup cycle so pready can stay high.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      unique case (paddr)
        cmd_pkg::ADDR_CTRL: prdata_q <= {31'h00000000, ctrl_en_q};
        cmd_pkg::ADDR_STATION: prdata_q <= {8'h00, station_q};
        cmd_pkg::ADDR_MODE: prdata_q <= {29'h00000000, out_of_service, mode_q};
        cmd_pkg::ADDR_FAIL: prdata_q <= {24'h000000, failure_q};
        cmd_pkg::ADDR_IRQ_STAT: prdata_q <= {27'h0000000, irq_stat_q};
        cmd_pkg::ADDR_IRQ_MASK: prdata_q <= {27'h0000000, irq_mask_q};
        cmd_pkg::ADDR_COUNT: prdata_q <= {drop_cnt_q, accept_cnt_q};
        cmd_pkg::ADDR_LAST: prdata_q <= last_q;
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

endmodule : serial_mode_command_parser

`default_nettype wire

// ---- verif/cmd_host_model.sv ----
// Host model that sends framed mode requests one byte per clock, with gap idle clocks after each byte.
`timescale 1ns/10ps
`default_nettype none
module cmd_host_model (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hex_ch
  // A released data line shows the inverse, so a stale byte never looks valid.
  task automatic put(input logic [7:0] b, input int gap);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk);
    if (gap > 0) begin
      rx_valid <= 1'b0;
      rx_data <= ~b;
      repeat (gap) @(posedge clk);
    end
  endtask : put
  task automatic send(input string body, input bit bad, input int gap);
    logic [7:0] x;
    x = 8'h02 ^ 8'h03;
    for (int i = 0; i < body.len(); i++) x = x ^ body[i];
    @(posedge clk);
    put(8'h02, gap);
    for (int i = 0; i < body.len(); i++) put(body[i], gap);
    put(8'h03, gap);
    put(hex_ch(x[7:4]), gap);
    put(hex_ch(x[3:0]) ^ {7'h0, bad}, gap);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask : send
endmodule : cmd_host_model
`default_nettype wire

// ---- verif/serial_mode_command_parser_checker.sv ----
// Port assertions for the serial mode command parser.
`timescale 1ns/10ps
`default_nettype none
module cmd_parser_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cmd_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic flow_fault,
  input wire logic instr_fault,
  input wire logic in_maintenance,
  input wire logic lamp_fault,
  input wire logic heater_fault,
  input wire logic [1:0] mode,
  input wire logic [7:0] failure_byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Eight samples cover the pin synchroniser delay with margin.
  a_flow_set: assert property ((flow_fault)[*8] |-> failure_byte[0])
    else $error("flow bit not set");
  a_flow_clear: assert property ((!flow_fault)[*8] |-> !failure_byte[0])
    else $error("flow bit stuck");
  a_instr_set: assert property ((instr_fault)[*8] |-> failure_byte[1])
    else $error("instrument bit not set");
  a_maint_not_fail: assert property ((in_maintenance && !instr_fault)[*8] |-> !failure_byte[1])
    else $error("maintenance shown as failure");
  a_lamp_set: assert property ((lamp_fault)[*8] |-> failure_byte[3])
    else $error("lamp bit not set");
  a_heater_set: assert property ((heater_fault)[*8] |-> failure_byte[5])
    else $error("heater bit not set");
  a_spare_zero: assert property (failure_byte[7:6] == 2'h0 && !failure_byte[4] && !failure_byte[2])
    else $error("spare failure bit set");
  a_mode_legal: assert property (mode != 2'h3)
    else $error("illegal mode");
  a_mode_by_byte: assert property ($changed(mode) |-> $past(rx_valid))
    else $error("mode changed without a byte");
  a_unmapped_err: assert property (psel && penable && !pwrite && paddr > 12'h01c
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  c_span: cover property (mode == 2'h2);
  c_faults: cover property (failure_byte == 8'h2b);
  c_err: cover property (pslverr);
endmodule : cmd_parser_checker
bind serial_mode_command_parser cmd_parser_checker chk_i (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .rx_valid(rx_valid), .flow_fault(flow_fault), .instr_fault(instr_fault),
  .in_maintenance(in_maintenance), .lamp_fault(lamp_fault), .heater_fault(heater_fault),
  .mode(mode), .failure_byte(failure_byte));
`default_nettype wire

// ---- verif/serial_mode_command_parser_tb_top.sv ----
// Self-checking testbench for the serial mode command parser.
`timescale 1ns/10ps
`default_nettype none
module serial_mode_command_parser_tb_top;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, rx_valid, irq, out_of_service, errq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic [3:0] pstrb;
  logic [7:0] rx_data, failure_byte;
  logic [4:0] flt;
  logic [1:0] mode;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // Identifier omitted or sent as three padded characters.
  string cmds[6] = '{"ST M", "ST000 N", "ST??? K", "ST999 M", "ST843 M", "ST843 X"};
  logic [1:0] md[6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};
  serial_mode_command_parser dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .flow_fault(flt[cmd_pkg::PIN_FLOW]), .instr_fault(flt[cmd_pkg::PIN_INSTR]),
    .in_maintenance(flt[cmd_pkg::PIN_MAINT]), .lamp_fault(flt[cmd_pkg::PIN_LAMP]),
    .heater_fault(flt[cmd_pkg::PIN_HEATER]), .mode(mode), .failure_byte(failure_byte),
    .out_of_service(out_of_service), .irq(irq));
  cmd_host_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  // The request holds until pready is seen high; one idle edge follows.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the bench timeout ends a wait for pready.
    while (pready !== 1'b1) @(posedge clk);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdq, e);
  endtask : rd
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    flt = 5'h00;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    chk({30'h0, mode}, 32'h0);
    rd(12'h014, 32'h0);
    rd(12'h004, 32'h303031);
    apb(1'b1, 12'h004, 32'h383433);
    apb(1'b1, 12'h014, 32'h1);
    host.send("ST843 K", 1'b0, 0);
    repeat (2) @(posedge clk);
    chk({30'h0, mode}, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rd(12'h01c, 32'h3834334b);
    apb(1'b1, 12'h010, 32'h1f);
    chk({31'h0, irq}, 32'h0);
    // Pacing that cycles through zero, one and two idle clocks exercises gaps between bytes.
    for (int i = 0; i < 6; i++) begin
      host.send(cmds[i], i == 4, i % 3);
      repeat (2) @(posedge clk);
      chk({30'h0, mode}, {30'h0, md[i]});
    end
    rd(12'h010, 32'h0000000f);
    rd(12'h018, 32'h00020004);
    // Clearing the counters keeps the parser enabled; a disabled parser ignores frames.
    apb(1'b1, 12'h000, 32'h3);
    rd(12'h018, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    host.send("ST843 M", 1'b0, 0);
    repeat (2) @(posedge clk);
    chk({30'h0, mode}, 32'h2);
    rd(12'h018, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    flt <= 5'h04;
    repeat (8) @(posedge clk);
    chk({24'h0, failure_byte}, 32'h0);
    chk({31'h0, out_of_service}, 32'h1);
    rd(12'h008, 32'h6);
    flt <= 5'h1f;
    repeat (8) @(posedge clk);
    chk({24'h0, failure_byte}, 32'h2b);
    rd(12'h00c, 32'h2b);
    apb(1'b0, 12'h020, 32'h0);
    chk(rdq, 32'h0);
    chk({31'h0, errq}, 32'h1);
    complete_run();
  end
endmodule : serial_mode_command_parser_tb_top
`default_nettype wire
